/* File: include/acs_params.svh */
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Register offsets on the plain register port
`define ACS_ADDR_W          4
`define ACS_OFF_STATUS      4'h0
`define ACS_OFF_ENABLE      4'h1
`define ACS_OFF_MODE        4'h2
`define ACS_OFF_SETTLE      4'h3
`define ACS_OFF_DIVIDE      4'h8
// Result slots sit at 4..7: address bits 3:2 equal 01
`define ACS_SLOT_PAGE       2'h1

// Field positions
`define ACS_EN_BIT          0
`define ACS_INTE_BIT        1
`define ACS_OVF_BIT         2

// Reset values
`define ACS_PTR_RST         2'h3
`define ACS_SETTLE_RST      8'h01
`define ACS_DIVIDE_RST      8'h31

// Mode codes of the scan field
`define ACS_SCAN_SINGLE     2'h0
`define ACS_SCAN_FOUR       2'h1

// Converter timing
`define ACS_SYS_CLK_NS      10
`define ACS_CONV_CLK_MIN_NS 500
`define ACS_CONV_TICKS      10
`define ACS_CHANNELS        12
`define ACS_SAR_TRIAL       8'h80

`endif

/* File: include/acs_pkg.sv */
`default_nettype none
package acs_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } acs_bus_req_t;

  typedef struct packed {
    logic       start;
    logic [1:0] scan;
    logic       repeat_select;
    logic [3:0] channel;
  } acs_mode_t;

  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_SAMPLE,
    ACS_SETTLE,
    ACS_CONVERT
  } acs_state_t;

endpackage : acs_pkg
`default_nettype wire

/* File: logic/acs_clkdiv.sv */
`include "acs_params.svh"
`default_nettype none
module acs_clkdiv
  import acs_pkg::*;
#(
  parameter int DIV_W      = 8,
  parameter int MIN_CYCLES = 50
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divide,
  output logic                  tick
);

  // The floor must fit the counter, or the 2 MHz ceiling is lost
  if (MIN_CYCLES < 2 || DIV_W < 1 || DIV_W > 16 ||
      MIN_CYCLES >= (1 << (DIV_W + 1))) begin : g_chk
    $error("acs_clkdiv: unsupported parameters");
  end

  logic [DIV_W:0] count_reg;
  logic [DIV_W:0] count_next;
  logic [DIV_W:0] limit;
  logic           tick_reg;
  logic           tick_next;
  logic [15:0]    gap_reg;

  // Fast settings are raised to the floor, so none beats the converter clock ceiling
  always_comb begin
    limit = {1'b0, divide} + (DIV_W+1)'(1);
    if (limit < (DIV_W+1)'(MIN_CYCLES)) begin
      limit = (DIV_W+1)'(MIN_CYCLES);
    end
    count_next = count_reg;
    tick_next  = 1'b0;
    if (!run) begin
      count_next = '0;
    end else if (count_reg >= limit - (DIV_W+1)'(1)) begin
      count_next = '0;
      tick_next  = 1'b1;
    end else begin
      count_next = count_reg + (DIV_W+1)'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else if (ce) begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick = tick_reg;

  always_ff @(posedge sys_clk) begin
    if (!nrst || !run) begin
      gap_reg <= 16'hffff;
    // Counts enabled edges only, so a frozen block is not a fast tick
    end else if (ce && tick_reg) begin
      gap_reg <= 16'h0001;
    end else if (ce && gap_reg != 16'hffff) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end

  a_tick_min_gap: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (ce && tick_reg) |-> gap_reg >= 16'(MIN_CYCLES))
    else $error("converter clock faster than allowed");

endmodule : acs_clkdiv
`default_nettype wire

/* File: logic/acs_result_mem.sv */
`default_nettype none
module acs_result_mem
  import acs_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int WIDTH = 8
) (
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  input  wire logic                     ce,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic                     re,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("acs_result_mem: unsupported parameters");
  end

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [WIDTH-1:0] rdata_reg;
  logic [WIDTH-1:0] rdata_next;

  always_comb begin
    mem_next   = mem_reg;
    rdata_next = rdata_reg;
    if (we) begin
      mem_next[waddr] = wdata;
    end
    // Read returns the value held before a same-cycle write
    if (re) begin
      rdata_next = mem_reg[raddr];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      rdata_reg <= '0;
    end else if (ce) begin
      mem_reg   <= mem_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

endmodule : acs_result_mem
`default_nettype wire

/* File: logic/acs_sequencer.sv */
// Summary of operation
// - Results are unsigned 8-bit, 00 hex at zero volts to FF at reference.
// - One of twelve inputs is routed to the converter by channel select.
// - A programmable settling delay follows sampling, same in every mode.
// - Converter clock comes from the system clock by a programmable divider.
// - A conversion takes ten converter clocks; that clock stays at 2 MHz max.
// - Four result slots, from one channel repeated or four adjacent channels.
// - Scan 00 single channel, 01 four-channel scan; repeat 0 once, 1 forever.
// - Single mode: one conversion into slot zero, clear start, set done.
// - With interrupt enabled, a pulse goes out when done is set.
// - Continuous single channel fills slots 0..3, done after slot three.
// - Continuous mode keeps start until cleared, wrapping slot three to zero.
// - Clearing start in continuous single channel ends after the current one.
// - Status holds a 2-bit pointer to the last written slot.
// - Scan converts four adjacent channels from the base into slots 0..3.
// - Reading any result slot clears the done flag.
// - Storing into an unread slot overwrites it and sets the overrun flag.
// - A start edge loads the pointer with 11; each store increments it.
`include "acs_params.svh"
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int SETTLE_W = 8,
  parameter int DIV_W    = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire acs_bus_req_t bus_req,
  output logic [7:0]        bus_rdata,
  input  wire logic         cmp_above,
  output logic [3:0]        chan_sel,
  output logic              sample_hold,
  output logic [7:0]        dac_code,
  output logic              conv_irq
);

  localparam int MIN_CYCLES =
    (`ACS_CONV_CLK_MIN_NS + `ACS_SYS_CLK_NS - 1) / `ACS_SYS_CLK_NS;

  if (SETTLE_W < 1 || SETTLE_W > 8 || DIV_W < 1 || DIV_W > 8) begin : g_chk
    $error("acs_sequencer: register fields are at most 8 bits");
  end

  function automatic logic is_slot(input logic [3:0] a);
    return a[3:2] == `ACS_SLOT_PAGE;
  endfunction : is_slot

  // Wraps past the last input so a scan never selects a reserved code
  function automatic logic [3:0] chan_add(input logic [3:0] b,
                                          input logic [1:0] o);
    logic [4:0] s;
    s = {1'b0, b} + {3'b000, o};
    if (s >= 5'(`ACS_CHANNELS)) begin
      s = s - 5'(`ACS_CHANNELS);
    end
    return s[3:0];
  endfunction : chan_add

  logic                enable_reg, enable_next;
  logic                inte_reg, inte_next;
  acs_mode_t           mode_reg, mode_next, mode_wr;
  logic [SETTLE_W-1:0] settle_reg, settle_next;
  logic [DIV_W-1:0]    divide_reg, divide_next;
  logic                eoc_reg, eoc_next;
  logic                ovf_reg, ovf_next;
  logic [1:0]          ptr_reg, ptr_next;
  logic [3:0]          unread_reg, unread_next;
  acs_state_t          state_reg, state_next;
  logic [7:0]          cnt_reg, cnt_next;
  logic [7:0]          code_reg, code_next;
  logic [2:0]          bit_reg, bit_next;
  logic                irq_reg, irq_next;
  logic [3:0]          chan_reg, chan_next;
  logic                cmp_meta_reg, cmp_sync_reg;
  logic                rd_slot_reg, rd_slot_next;
  logic [7:0]          rdata_reg, rdata_next;
  logic [7:0]          mem_rdata;
  logic                tick;
  logic                wr_en, rd_en, start_edge, res_we, done, group_end;
  logic [1:0]          wr_slot;

  assign wr_en   = ce && bus_req.wr;
  assign rd_en   = ce && bus_req.rd;
  assign mode_wr = acs_mode_t'(bus_req.wdata);
  assign wr_slot = ptr_reg + 2'h1;
  // Start only counts when enabled and the start bit is not already set
  assign start_edge = wr_en && bus_req.addr == `ACS_OFF_MODE &&
                      !mode_reg.start && mode_wr.start && enable_reg;

  acs_clkdiv #(
    .DIV_W      (DIV_W),
    .MIN_CYCLES (MIN_CYCLES)
  ) u_clkdiv (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ce      (ce),
    .run     (state_reg != ACS_IDLE),
    .divide  (divide_reg),
    .tick    (tick)
  );

  acs_result_mem #(
    .DEPTH (4),
    .WIDTH (8)
  ) u_mem (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ce      (ce),
    .we      (res_we),
    .waddr   (wr_slot),
    .wdata   (code_reg),
    .re      (rd_en && is_slot(bus_req.addr)),
    .raddr   (bus_req.addr[1:0]),
    .rdata   (mem_rdata)
  );

  always_comb begin
    enable_next = enable_reg;
    inte_next   = inte_reg;
    mode_next   = mode_reg;
    settle_next = settle_reg;
    divide_next = divide_reg;
    eoc_next    = eoc_reg;
    ovf_next    = ovf_reg;
    ptr_next    = ptr_reg;
    unread_next = unread_reg;
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    code_next   = code_reg;
    bit_next    = bit_reg;
    irq_next    = 1'b0;
    res_we      = 1'b0;
    done        = 1'b0;
    group_end   = wr_slot == 2'h3;
    if (ce) begin
      if (wr_en) begin
        case (bus_req.addr)
          `ACS_OFF_ENABLE: begin
            enable_next = bus_req.wdata[`ACS_EN_BIT];
            inte_next   = bus_req.wdata[`ACS_INTE_BIT];
          end
          `ACS_OFF_MODE: begin
            if (mode_reg.start) begin
              mode_next.start = mode_wr.start;
            end else begin
              mode_next       = mode_wr;
              mode_next.start = mode_wr.start && enable_reg;
            end
          end
          `ACS_OFF_SETTLE: settle_next = bus_req.wdata[SETTLE_W-1:0];
          `ACS_OFF_DIVIDE: divide_next = bus_req.wdata[DIV_W-1:0];
          `ACS_OFF_STATUS: begin
            if (bus_req.wdata[`ACS_OVF_BIT]) begin
              ovf_next = 1'b0;
            end
          end
          default: ;
        endcase
      end
      if (rd_en && is_slot(bus_req.addr)) begin
        eoc_next = 1'b0;
        unread_next[bus_req.addr[1:0]] = 1'b0;
      end
      unique case (state_reg)
        ACS_IDLE: begin
          if (start_edge) begin
            ptr_next   = `ACS_PTR_RST;
            state_next = ACS_SAMPLE;
          end
        end
        ACS_SAMPLE: begin
          if (tick) begin
            state_next = ACS_SETTLE;
            cnt_next   = 8'(settle_reg);
          end
        end
        ACS_SETTLE: begin
          if (tick) begin
            if (cnt_reg == 8'h00) begin
              state_next = ACS_CONVERT;
              code_next  = `ACS_SAR_TRIAL;
              bit_next   = 3'h7;
            end else begin
              cnt_next = cnt_reg - 8'h01;
            end
          end
        end
        ACS_CONVERT: begin
          if (tick) begin
            // Successive approximation, MSB first, one bit per tick
            if (cnt_reg < 8'h08) begin
              code_next[bit_reg] = cmp_sync_reg;
              if (bit_reg != 3'h0) begin
                code_next[3'(bit_reg - 3'h1)] = 1'b1;
              end
              bit_next = bit_reg - 3'h1;
            end
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'(`ACS_CONV_TICKS - 1)) begin
              res_we   = 1'b1;
              cnt_next = 8'h00;
              ptr_next = wr_slot;
              unread_next[wr_slot] = 1'b1;
              if (unread_reg[wr_slot]) begin
                ovf_next = 1'b1;
              end
              // Scan ends on slot three, one channel on every store
              if (!mode_reg.repeat_select) begin
                done = mode_reg.scan != `ACS_SCAN_FOUR || group_end;
              end else begin
                done = !mode_next.start &&
                       (mode_reg.scan != `ACS_SCAN_FOUR || group_end);
              end
              if (done || (mode_reg.repeat_select && group_end)) begin
                eoc_next = 1'b1;
                irq_next = inte_reg;
              end
              if (done) begin
                state_next = ACS_IDLE;
                if (!mode_reg.repeat_select) begin
                  mode_next.start = 1'b0;
                end
              end else begin
                state_next = ACS_SAMPLE;
              end
            end
          end
        end
      endcase
      if (!enable_next) begin
        // Disabling drops the sequence and its flags at once
        state_next      = ACS_IDLE;
        mode_next.start = 1'b0;
        eoc_next        = 1'b0;
        ovf_next        = 1'b0;
        irq_next        = 1'b0;
        res_we          = 1'b0;
      end
    end
  end

  // Scan walks the channels with the slot being filled
  always_comb begin
    if (mode_reg.scan == `ACS_SCAN_FOUR) begin
      chan_next = chan_add(mode_reg.channel, wr_slot);
    end else begin
      chan_next = chan_add(mode_reg.channel, 2'h0);
    end
  end

  always_comb begin
    rd_slot_next = 1'b0;
    rdata_next   = 8'h00;
    if (rd_en) begin
      rd_slot_next = is_slot(bus_req.addr);
      case (bus_req.addr)
        `ACS_OFF_STATUS: rdata_next = {2'b00, ptr_reg, 1'b0, ovf_reg,
                                       state_reg != ACS_IDLE, eoc_reg};
        `ACS_OFF_ENABLE: rdata_next = {6'h00, inte_reg, enable_reg};
        `ACS_OFF_MODE:   rdata_next = mode_reg;
        `ACS_OFF_SETTLE: rdata_next = 8'(settle_reg);
        `ACS_OFF_DIVIDE: rdata_next = 8'(divide_reg);
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      enable_reg   <= 1'b0;
      inte_reg     <= 1'b0;
      mode_reg     <= '0;
      settle_reg   <= SETTLE_W'(`ACS_SETTLE_RST);
      divide_reg   <= DIV_W'(`ACS_DIVIDE_RST);
      eoc_reg      <= 1'b0;
      ovf_reg      <= 1'b0;
      ptr_reg      <= `ACS_PTR_RST;
      unread_reg   <= 4'h0;
      state_reg    <= ACS_IDLE;
      cnt_reg      <= 8'h00;
      code_reg     <= 8'h00;
      bit_reg      <= 3'h7;
      irq_reg      <= 1'b0;
      chan_reg     <= 4'h0;
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
      rd_slot_reg  <= 1'b0;
      rdata_reg    <= 8'h00;
    end else if (ce) begin
      enable_reg   <= enable_next;
      inte_reg     <= inte_next;
      mode_reg     <= mode_next;
      settle_reg   <= settle_next;
      divide_reg   <= divide_next;
      eoc_reg      <= eoc_next;
      ovf_reg      <= ovf_next;
      ptr_reg      <= ptr_next;
      unread_reg   <= unread_next;
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      code_reg     <= code_next;
      bit_reg      <= bit_next;
      irq_reg      <= irq_next;
      chan_reg     <= chan_next;
      cmp_meta_reg <= cmp_above;
      cmp_sync_reg <= cmp_meta_reg;
      rd_slot_reg  <= rd_slot_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign bus_rdata   = rd_slot_reg ? mem_rdata : rdata_reg;
  assign chan_sel    = chan_reg;
  assign sample_hold = state_reg == ACS_SAMPLE;
  assign dac_code    = code_reg;
  assign conv_irq    = irq_reg;

  a_start_when_off: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (wr_en && bus_req.addr == `ACS_OFF_MODE && !enable_reg &&
     !mode_reg.start) |=> !mode_reg.start)
    else $error("start accepted while disabled");

  a_disable_aborts: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (wr_en && bus_req.addr == `ACS_OFF_ENABLE &&
     !bus_req.wdata[`ACS_EN_BIT]) |=>
    state_reg == ACS_IDLE && !mode_reg.start && !eoc_reg && !ovf_reg)
    else $error("disable did not abort");

  a_ptr_load: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    start_edge && state_reg == ACS_IDLE |=>
    ptr_reg == 2'h3 && state_reg == ACS_SAMPLE)
    else $error("pointer not loaded on start");

  a_ptr_advance: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    res_we |=> ptr_reg == $past(ptr_reg) + 2'h1 && unread_reg[ptr_reg])
    else $error("pointer did not follow the store");

  a_single_done: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (res_we && !mode_reg.repeat_select && mode_reg.scan == `ACS_SCAN_SINGLE) |=>
    !mode_reg.start && eoc_reg && state_reg == ACS_IDLE && ptr_reg == 2'h0)
    else $error("single conversion did not finish");

  // Done may already be set in continuous mode; the pulse still follows
  a_irq_with_eoc: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (conv_irq && $past(ce)) |->
    eoc_reg && $past(inte_reg) && $past(state_reg == ACS_CONVERT))
    else $error("interrupt without a fresh done flag");

  a_ovf_on_full: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (res_we && unread_reg[wr_slot]) |=> ovf_reg)
    else $error("overrun not flagged");

  a_eoc_read_clr: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (rd_en && is_slot(bus_req.addr) && !res_we && enable_reg) |=> !eoc_reg)
    else $error("slot read left done set");

  a_repeat_select_keeps: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (res_we && mode_reg.repeat_select && mode_next.start) |=>
    state_reg == ACS_SAMPLE && mode_reg.start)
    else $error("continuous mode stopped by itself");

endmodule : acs_sequencer
`default_nettype wire

/* File: verification/acs_tb.sv */
`include "acs_params.svh"
`default_nettype none
module testbench
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic         sys_clk;
  logic         nrst;
  logic         ce;
  acs_bus_req_t bus_req;
  logic [7:0]   bus_rdata;
  logic         cmp_above;
  logic [3:0]   chan_sel;
  logic         sample_hold;
  logic [7:0]   dac_code;
  logic         conv_irq;
  logic [7:0]   analog [12];
  logic [3:0]   ch;
  logic [7:0]   sv;
  logic [7:0]   dv;
  int           fail_count = 0;
  int           n_compared = 0;
  int           irq_cnt    = 0;
  int           cyc        = 0;
  int           seed;
  int           n;
  int           i0;
  int           ex;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  acs_sequencer uut (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .ce          (ce),
    .bus_req     (bus_req),
    .bus_rdata   (bus_rdata),
    .cmp_above   (cmp_above),
    .chan_sel    (chan_sel),
    .sample_hold (sample_hold),
    .dac_code    (dac_code),
    .conv_irq    (conv_irq)
  );

  // Input sits half a step above its code, so the search lands on it exactly
  always @(posedge sys_clk) begin
    cmp_above <= (chan_sel < 4'hc) && (dac_code <= analog[chan_sel]);
    cyc <= cyc + 1;
    if (conv_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
    if (cyc == 60000) begin
      fail_count = fail_count + 1;
      results();
    end
  end

  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic chk_win(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_win

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    bus_req.wr    <= 1'b1;
    bus_req.addr  <= a;
    bus_req.wdata <= v;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Read and compare; data stand only in the cycle after the strobe
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_req.rd   <= 1'b1;
    bus_req.addr <= a;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    n_compared++;
    if (bus_rdata !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, bus_rdata, exp);
    end
  endtask : rc

  // Cycles from the end of sampling to the completion pulse
  task automatic wait_irq(output int cnt);
    int k;
    cnt = 0;
    k = 0;
    @(posedge sys_clk);
    #1;
    while (sample_hold === 1'b1 && k < 5000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    while (conv_irq !== 1'b1 && cnt < 20000) begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    chk_win(cnt, 0, 19999);
  endtask : wait_irq

  // Mode is only changed with the converter off, then the start-up wait
  task automatic restart(input logic [7:0] en);
    wr(`ACS_OFF_ENABLE, 8'h00);
    wr(`ACS_OFF_ENABLE, en);
    repeat (3000) @(posedge sys_clk);
  endtask : restart

  function automatic logic [7:0] md(input logic st, input logic [1:0] sc,
                                    input logic ct, input logic [3:0] c);
    return {st, sc, ct, c};
  endfunction : md

  function automatic int per(input logic [7:0] d);
    return (int'(d) + 1 > 50) ? int'(d) + 1 : 50;
  endfunction : per

  initial begin
    seed      = 32'h0f32;
    nrst      = 1'b0;
    ce        = 1'b1;
    bus_req   = '0;
    cmp_above = 1'b0;
    for (int i = 0; i < 12; i++) begin
      analog[i] = 8'($random(seed));
    end
    analog[0]  = 8'h00;
    analog[11] = 8'hff;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    rc(`ACS_OFF_STATUS, 8'h30);
    rc(`ACS_OFF_ENABLE, 8'h00);
    rc(`ACS_OFF_MODE, 8'h00);
    rc(`ACS_OFF_SETTLE, `ACS_SETTLE_RST);
    rc(`ACS_OFF_DIVIDE, `ACS_DIVIDE_RST);
    wr(4'h9, 8'h5a);
    rc(4'h9, 8'h00);
    wr(`ACS_OFF_MODE, 8'h80);
    rc(`ACS_OFF_MODE, 8'h00);
    rc(`ACS_OFF_STATUS, 8'h30);
    // Single conversions: settle and divider corners, top channel first
    restart(8'h03);
    for (int k = 0; k < 3; k++) begin
      sv = (k == 1) ? 8'h03 : 8'h00;
      dv = (k == 2) ? 8'h63 : 8'h00;
      ch = (k == 0) ? 4'hb : 4'({$random(seed)} % 12);
      wr(`ACS_OFF_SETTLE, sv);
      wr(`ACS_OFF_DIVIDE, dv);
      i0 = irq_cnt;
      wr(`ACS_OFF_MODE, md(1'b1, 2'h0, 1'b0, ch));
      wait_irq(n);
      ex = (int'(sv) + 11) * per(dv);
      chk_win(n, ex - 2, ex + 3);
      rc(`ACS_OFF_STATUS, 8'h01);
      chk_win(irq_cnt - i0, 1, 1);
      rc(`ACS_OFF_MODE, md(1'b0, 2'h0, 1'b0, ch));
      rc(4'h4, analog[ch]);
      rc(`ACS_OFF_STATUS, 8'h00);
    end
    // One channel, continuous, stopped after the wrap into slot zero
    ch = 4'({$random(seed)} % 12);
    wr(`ACS_OFF_DIVIDE, 8'h00);
    wr(`ACS_OFF_SETTLE, 8'h00);
    restart(8'h03);
    i0 = irq_cnt;
    wr(`ACS_OFF_MODE, md(1'b1, 2'h0, 1'b1, ch));
    wait_irq(n);
    rc(`ACS_OFF_STATUS, 8'h33);
    chk_win(irq_cnt - i0, 1, 1);
    rc(`ACS_OFF_MODE, md(1'b1, 2'h0, 1'b1, ch));
    wr(`ACS_OFF_MODE, md(1'b0, 2'h0, 1'b1, ch));
    wait_irq(n);
    rc(`ACS_OFF_STATUS, 8'h05);
    for (int i = 0; i < 4; i++) begin
      rc(4'(4 + i), analog[ch]);
    end
    wr(`ACS_OFF_STATUS, 8'h04);
    rc(`ACS_OFF_STATUS, 8'h00);
    // Four-channel scan, once and continuous; base 10 wraps past 11
    for (int c = 0; c < 2; c++) begin
      ch = (c == 0) ? 4'ha : 4'({$random(seed)} % 12);
      restart(8'h03);
      wr(`ACS_OFF_MODE, md(1'b1, 2'h1, c[0], ch));
      wait_irq(n);
      if (c == 1) begin
        // Drain the first group before the wrap, so no overrun follows
        for (int i = 0; i < 4; i++) begin
          rc(4'(4 + i), analog[(ch + i) % 12]);
        end
        rc(`ACS_OFF_MODE, md(1'b1, 2'h1, 1'b1, ch));
        wr(`ACS_OFF_MODE, md(1'b0, 2'h1, 1'b1, ch));
        wait_irq(n);
        rc(`ACS_OFF_STATUS, 8'h31);
      end
      rc(`ACS_OFF_MODE, md(1'b0, 2'h1, c[0], ch));
      for (int i = 0; i < 4; i++) begin
        rc(4'(4 + i), analog[(ch + i) % 12]);
      end
    end
    // Disable during the settling delay aborts without a completion pulse
    restart(8'h03);
    wr(`ACS_OFF_SETTLE, 8'h0f);
    wr(`ACS_OFF_MODE, md(1'b1, 2'h0, 1'b0, ch));
    repeat (200) @(posedge sys_clk);
    i0 = irq_cnt;
    wr(`ACS_OFF_ENABLE, 8'h00);
    rc(`ACS_OFF_STATUS, 8'h30);
    rc(`ACS_OFF_MODE, md(1'b0, 2'h0, 1'b0, ch));
    repeat (1500) @(posedge sys_clk);
    chk_win(irq_cnt - i0, 0, 0);
    // Interrupt disabled: flag still set, no pulse
    wr(`ACS_OFF_SETTLE, 8'h00);
    restart(8'h01);
    i0 = irq_cnt;
    wr(`ACS_OFF_MODE, md(1'b1, 2'h0, 1'b0, ch));
    repeat (1000) @(posedge sys_clk);
    rc(`ACS_OFF_STATUS, 8'h01);
    chk_win(irq_cnt - i0, 0, 0);
    rc(4'h4, analog[ch]);
    results();
  end
endmodule : testbench
`default_nettype wire
